// File: logic/wtm_defs.svh
// constants of the wide timer: register offsets, field positions, reset values
// assumes an apb slave with 32-bit data, one register per aligned word
//
// Overview of operation
// - rate code held in mode bits 6..4
// - code 000 divides by 256, 111 by 2
// - 16-bit up count in two r/w bytes
// - event mode counts edges, holds when disabled
// - external source with direction one counts rises
// - measure bit selects width measurement mode
// - width measurement counts prescaled internal ticks
// - code 10 measures high pulse width
// - code 11 measures low pulse width
// - flag clear waits for start edge
// - stop edge sets flag, halts, latches count
// - clearing flag re-arms measurement automatically
// - reads show latched or live count
// - overflow sets flag, auto-recount decides continue
`ifndef WTM_DEFS_SVH
`define WTM_DEFS_SVH

// byte addresses
`define WTM_MODE_OFS   12'h000
`define WTM_CNTL_OFS   12'h004
`define WTM_CNTH_OFS   12'h008
`define WTM_STAT_OFS   12'h00c
`define WTM_MASK_OFS   12'h010

// mode register fields
`define WTM_EN_BIT     7
`define WTM_RATE_HI    6
`define WTM_RATE_LO    4
`define WTM_CKS_BIT    3
`define WTM_ARC_BIT    2
`define WTM_G1_BIT     1
`define WTM_G0_BIT     0

// status bits: overflow, measurement done
`define WTM_ST_OVF     0
`define WTM_ST_MEAS    1
`define WTM_NUM_EVT    2

`define WTM_MODE_RST   8'h00
`define WTM_CNT_RST    16'h0000
`define WTM_PRE_W      8

`endif

// File: logic/wtm_pkg.sv
// types of the wide timer
// assumes the defs header supplies numbers
package wtm_pkg;
  typedef enum logic [1:0] {WTM_IDLE, WTM_ARMED, WTM_MEAS, WTM_DONE} wtm_meas_t;
endpackage

// File: logic/wtm_prescaler.sv
// free running prescaler giving one-cycle tick at pclk / 2^(8-rate)
// assumes pclk is the instruction clock
`timescale 1ns/1ps
`default_nettype none
`include "wtm_defs.svh"
module wtm_prescaler
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [2:0] rate,
  output logic            tick
);
  logic [`WTM_PRE_W-1:0] div_reg;
  logic [`WTM_PRE_W-1:0] div_next;
  logic [`WTM_PRE_W-1:0] lim;

  // rate 000 -> 256, 111 -> 2
  assign lim      = 8'hff >> rate;
  assign div_next = (div_reg >= lim) ? 8'h00 : div_reg + 8'h01;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_reg <= 8'h00;
      tick    <= 1'b0;
    end
    else
    begin
      div_reg <= div_next;
      tick    <= (div_reg >= lim);
    end
  end
endmodule
`default_nettype wire

// File: logic/wtm_sync.sv
// two flip-flop synchroniser for the input pin
// assumes a single pclk domain
`timescale 1ns/1ps
`default_nettype none
module wtm_sync
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic d,
  output logic      q
);
  logic meta_reg;

  // first stage read only by second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_reg <= 1'b0;
      q        <= 1'b0;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// File: logic/wtm_top.sv
// wide timer: 16-bit timer, event counter and pulse width measure, apb slave
// assumes pclk is the instruction clock and the input pin is asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "wtm_defs.svh"
module wtm_top
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        event_input_pin,
  output logic             wide_timer_irq
);

  ////////////////////////////////////////////////////////////////////////
  // registers and wires
  logic [7:0]  mode_reg;
  logic [15:0] cnt_reg;
  logic [`WTM_NUM_EVT-1:0] stat_reg;
  logic [`WTM_NUM_EVT-1:0] mask_reg;
  logic        pin_s;
  logic        pin_d_reg;
  logic        tick;
  wtm_pkg::wtm_meas_t meas_reg;
  wtm_pkg::wtm_meas_t meas_next;

  wtm_sync u_sync
  (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (event_input_pin),
    .q       (pin_s)
  );

  wtm_prescaler u_pre
  (
    .pclk    (pclk),
    .presetn (presetn),
    .rate    (mode_reg[`WTM_RATE_HI:`WTM_RATE_LO]),
    .tick    (tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // apb decode; zero wait state, unmapped gives slverr
  wire acc      = psel & penable;
  wire wr       = acc & pwrite;
  wire sel_mode = (paddr == `WTM_MODE_OFS);
  wire sel_cntl = (paddr == `WTM_CNTL_OFS);
  wire sel_cnth = (paddr == `WTM_CNTH_OFS);
  wire sel_stat = (paddr == `WTM_STAT_OFS);
  wire sel_mask = (paddr == `WTM_MASK_OFS);
  wire mapped   = sel_mode | sel_cntl | sel_cnth | sel_stat | sel_mask;
  wire wr_mode  = wr & sel_mode;
  wire wr_cntl  = wr & sel_cntl;
  wire wr_cnth  = wr & sel_cnth;
  wire wr_stat  = wr & sel_stat;
  wire wr_mask  = wr & sel_mask;

  // read words, zero above the byte; count bytes always show the counter:
  // latched when halted, live otherwise
  wire [31:0] rd_mode = {24'h000000, mode_reg};
  wire [31:0] rd_cntl = {24'h000000, cnt_reg[7:0]};
  wire [31:0] rd_cnth = {24'h000000, cnt_reg[15:8]};
  wire [31:0] rd_stat = {30'h0, stat_reg};
  wire [31:0] rd_mask = {30'h0, mask_reg};
  wire [31:0] rd_mux =
    sel_mode ? rd_mode :
    sel_cntl ? rd_cntl :
    sel_cnth ? rd_cnth :
    sel_stat ? rd_stat :
    sel_mask ? rd_mask : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////
  // mode fields
  wire en      = mode_reg[`WTM_EN_BIT];
  wire cks     = mode_reg[`WTM_CKS_BIT];
  wire arc     = mode_reg[`WTM_ARC_BIT];
  wire g1      = mode_reg[`WTM_G1_BIT];  // measure enable
  wire g0      = mode_reg[`WTM_G0_BIT];

  // edges of the synchronised pin
  wire rise    = pin_s & ~pin_d_reg;
  wire fall    = ~pin_s & pin_d_reg;
  // event mode: g0=1 rising, g0=0 falling
  wire ev_edge = g0 ? rise : fall;
  // measure: high pulse starts on rise, low pulse on fall
  wire m_start = g0 ? fall : rise;
  wire m_stop  = g0 ? rise : fall;

  wire irq_flag = stat_reg[`WTM_ST_OVF] | stat_reg[`WTM_ST_MEAS];

  ////////////////////////////////////////////////////////////////////////
  // measurement sequencer
  always_comb
  begin
    meas_next = meas_reg;
    // dropping enable or the measure bit returns to idle from any state;
    // a pending overflow flag also blocks the start edge
    case (meas_reg)
      // armed once enable and the measure bit are both set
      wtm_pkg::WTM_IDLE:
        if (en && g1)
          meas_next = wtm_pkg::WTM_ARMED;
      wtm_pkg::WTM_ARMED:
        if (!(en && g1))
          meas_next = wtm_pkg::WTM_IDLE;
        else if (!irq_flag && m_start)
          meas_next = wtm_pkg::WTM_MEAS;  // wait for start edge
      wtm_pkg::WTM_MEAS:
        if (!(en && g1))
          meas_next = wtm_pkg::WTM_IDLE;
        else if (m_stop)
          meas_next = wtm_pkg::WTM_DONE;  // halt and hold count
      // count holds here until software clears the done flag
      wtm_pkg::WTM_DONE:
        if (!(en && g1))
          meas_next = wtm_pkg::WTM_IDLE;
        else if (!stat_reg[`WTM_ST_MEAS])
          meas_next = wtm_pkg::WTM_ARMED; // re-arm once flag cleared
      default:
        meas_next = wtm_pkg::WTM_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // counting
  // overflow stop without auto-recount waits for the flag to clear
  wire ovf_hold = ~arc & stat_reg[`WTM_ST_OVF];
  // measurement counts prescaled internal ticks, not pin edges
  wire inc_tmr  = en & ~g1 & ~cks & tick;
  wire inc_evt  = en & ~g1 & cks & ev_edge;  // one per selected edge
  wire inc_meas = (meas_reg == wtm_pkg::WTM_MEAS) & tick & ~m_stop;
  // disabled enable bit leaves count untouched, except one measure tick in the cycle before the sequencer drops to idle
  wire inc      = (inc_tmr | inc_evt | inc_meas) & ~ovf_hold;
  wire ovf      = inc & (cnt_reg == 16'hffff);
  wire meas_ev  = (meas_reg == wtm_pkg::WTM_MEAS) & (meas_next == wtm_pkg::WTM_DONE);

  wire [`WTM_NUM_EVT-1:0] evt = {meas_ev, ovf};
  // hardware set wins over write-one clear
  wire [`WTM_NUM_EVT-1:0] stat_next =
    (stat_reg & ~(wr_stat ? pwdata[`WTM_NUM_EVT-1:0] : 2'b00)) | evt;

  wire [15:0] cnt_inc = cnt_reg + 16'h0001;  // exactly one step

  // a bus write to either byte beats a tick in the same cycle;
  // software writing a running count may lose that one step
  wire [15:0] cnt_next =
    wr_cntl ? {cnt_reg[15:8], pwdata[7:0]} :
    wr_cnth ? {pwdata[7:0], cnt_reg[7:0]} :
    inc     ? cnt_inc :                       // wraps to zero, goes on with arc, else holds until the flag clears
              cnt_reg;

  // bus next values; every output is taken from a flop
  wire        pready_next  = psel & ~penable;  // ready one cycle after setup
  wire        pslverr_next = psel & ~penable & ~mapped;
  wire [31:0] prdata_next  = (psel & ~penable & ~pwrite) ? rd_mux : 32'h00000000;
  // set value used, so the request follows an event without extra delay
  wire        irq_next     = |(stat_next & mask_reg);  // only enabled sources

  ////////////////////////////////////////////////////////////////////////
  // state flops, one short process per register

  // previous pin level; reset low like the idle pin, so no false edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_d_reg <= 1'b0;
    end
    else
    begin
      pin_d_reg <= pin_s;
    end
  end

  // measurement sequencer state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meas_reg <= wtm_pkg::WTM_IDLE;
    end
    else
    begin
      meas_reg <= meas_next;
    end
  end

  // sticky status: overflow and measurement done
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_reg <= 2'b00;
    end
    else
    begin
      stat_reg <= stat_next;  // overflow and done flags
    end
  end

  // mode register, written whole
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_reg <= `WTM_MODE_RST;
    end
    else if (wr_mode)
    begin
      mode_reg <= pwdata[7:0];  // rate in bits 6..4
    end
  end

  // interrupt mask, same layout as status
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mask_reg <= 2'b00;
    end
    else if (wr_mask)
    begin
      mask_reg <= pwdata[`WTM_NUM_EVT-1:0];
    end
  end

  // count, no shadow copy, so a read between bytes may tear while running
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_reg <= `WTM_CNT_RST;
    end
    else
    begin
      cnt_reg <= cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus outputs and interrupt, all registered

  // read data stands only in the access cycle, zero otherwise
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
    end
    else
    begin
      prdata <= prdata_next;
    end
  end

  // ready with zero wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
    end
    else
    begin
      pready <= pready_next;
    end
  end

  // error for an unmapped address; writes there are dropped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pslverr <= 1'b0;
    end
    else
    begin
      pslverr <= pslverr_next;
    end
  end

  // level interrupt request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wide_timer_irq <= 1'b0;
    end
    else
    begin
      wide_timer_irq <= irq_next;
    end
  end

endmodule
`default_nettype wire

// File: testbench/tb_wtm_top.sv
// bench for the wide timer: apb master, pulse source, random widths
// assumes design, pulse source and checker compile before it
`timescale 1ns/1ps
`default_nettype none
`include "wtm_defs.svh"
module tb_wtm_top;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, rd2;
  logic        pready, pslverr, pin, irq, go = 1'b0;
  logic [15:0] hi_len = 16'h0004, lo_len = 16'h0004;
  int          fail_count = 0, n_compared = 0, seed = 39620, i, k, h, n;
  // 100 MHz clock
  always #5 pclk = ~pclk;
  wtm_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .event_input_pin(pin), .wide_timer_irq(irq));
  wtm_pulse_src u_src (.pclk(pclk), .go(go), .hi_len(hi_len), .lo_len(lo_len), .pin(pin));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; waits for ready, however long it takes
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d); bus(1'b1, a, d, rd2); endtask
  // count is read high byte first; only done while stopped
  task rdcnt(output logic [31:0] c);
    logic [31:0] hb;
    bus(1'b0, `WTM_CNTH_OFS, 32'h0, hb);
    bus(1'b0, `WTM_CNTL_OFS, 32'h0, c);
    c = {16'h0, hb[7:0], c[7:0]};
  endtask
  task zero; wr(`WTM_CNTL_OFS, 32'h0); wr(`WTM_CNTH_OFS, 32'h0); endtask
  // prescaler phase is unknown, so allow one tick either way
  function logic [31:0] near(input logic [31:0] got, input logic [31:0] e);
    return {31'h0, got + 1 >= e && got <= e + 1};
  endfunction
  task conclude;
    $display("mismatches %0d compares %0d", fail_count, n_compared);
    if (fail_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog, well beyond the ~10k cycles the run needs
  initial
  begin
    repeat (80000) @(posedge pclk);
    fail_count++;
    conclude;
  end
  // main sequence
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i <= 20; i += 4)
    begin
      bus(1'b0, i[11:0], 32'h0, rd);
      chk(rd, 32'h0);
    end
    k = $random(seed);
    wr(`WTM_MODE_OFS, 32'(k & 127));
    bus(1'b0, `WTM_MODE_OFS, 32'h0, rd);
    chk(rd, 32'(k & 127));
    wr(`WTM_CNTL_OFS, 32'(k >> 8 & 255));
    wr(`WTM_CNTH_OFS, 32'(k >> 16 & 255));
    rdcnt(rd);
    chk(rd, 32'(k >> 8 & 65535));
    for (i = 0; i < 8; i++)
    begin
      zero;
      wr(`WTM_MODE_OFS, 32'(128 + i * 16));
      repeat (1024) @(posedge pclk);
      wr(`WTM_MODE_OFS, 32'(i * 16));
      rdcnt(rd);
      chk(near(rd, 32'(1027 >> (8 - i))), 32'h1);
    end
    repeat (40) @(posedge pclk);
    rdcnt(rd2);
    chk(rd2, rd);
    wr(`WTM_CNTL_OFS, 32'hfc); wr(`WTM_CNTH_OFS, 32'hff); wr(`WTM_MASK_OFS, 32'h1);
    wr(`WTM_MODE_OFS, 32'hf0);
    repeat (40) @(posedge pclk);
    rdcnt(rd);
    chk(rd, 32'h0);
    bus(1'b0, `WTM_STAT_OFS, 32'h0, rd);
    chk(rd, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(`WTM_MASK_OFS, 32'h0);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(`WTM_MODE_OFS, 32'h0); wr(`WTM_STAT_OFS, 32'h1);
    bus(1'b0, `WTM_STAT_OFS, 32'h0, rd);
    chk(rd, 32'h0);
    // auto-recount: 43 enabled cycles give 21 or 22 ticks, 17 or 18 past the wrap
    wr(`WTM_CNTL_OFS, 32'hfc); wr(`WTM_CNTH_OFS, 32'hff);
    wr(`WTM_MODE_OFS, 32'hf4);
    repeat (40) @(posedge pclk);
    wr(`WTM_MODE_OFS, 32'h0);
    rdcnt(rd);
    chk(near(rd, 32'h11), 32'h1);
    bus(1'b0, `WTM_STAT_OFS, 32'h0, rd);
    chk(rd, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(`WTM_STAT_OFS, 32'h1);
    // event counting on falling, then rising edges
    for (i = 0; i < 2; i++)
    begin
      zero;
      wr(`WTM_MODE_OFS, 32'(136 + i));
      h = 4 + ($random(seed) & 7);
      k = 3 + ($random(seed) & 7);
      hi_len <= h[15:0]; lo_len <= h[15:0] + 16'h2; go <= 1'b1;
      repeat (k * (2 * h + 2)) @(posedge pclk);
      go <= 1'b0;
      repeat (8) @(posedge pclk);
      wr(`WTM_MODE_OFS, 32'(8 + i));
      rdcnt(rd);
      chk(rd, 32'(k));
    end
    // width of high, then low pulses, measured twice to see re-arm
    wr(`WTM_MASK_OFS, 32'h2);
    for (i = 0; i < 2; i++)
    begin
      h = 20 + 2 * ($random(seed) & 15);
      hi_len <= h[15:0]; lo_len <= h[15:0] + 16'd10; go <= 1'b1;
      zero; wr(`WTM_STAT_OFS, 32'h3);
      wr(`WTM_MODE_OFS, 32'(242 + i));
      for (k = 0; k < 2; k++)
      begin
        repeat (2) @(posedge pclk);
        for (n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        rdcnt(rd);
        chk(near(rd, 32'((h + 10 * i) / 2)), 32'h1);
        zero; wr(`WTM_STAT_OFS, 32'h2);
      end
      go <= 1'b0;
      wr(`WTM_MODE_OFS, 32'h0);
    end
    conclude;
  end
endmodule
bind wtm_top wtm_top_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .event_input_pin(event_input_pin),
  .wide_timer_irq(wide_timer_irq));
`default_nettype wire

// File: testbench/wtm_pulse_src.sv
// pulse source on the event input pin: high phase, then low phase
// assumes the bench sets both widths before raising go
`timescale 1ns/1ps
`default_nettype none
module wtm_pulse_src
(
  input  wire logic        pclk,
  input  wire logic        go,
  input  wire logic [15:0] hi_len,
  input  wire logic [15:0] lo_len,
  output logic             pin
);
  logic [15:0] phase_reg;
  // each period opens with a rise; idle low, like a pulled-down line
  always_ff @(posedge pclk)
  begin
    if (!go)
    begin
      phase_reg <= 16'h0000;
      pin       <= 1'b0;
    end
    else
    begin
      pin       <= phase_reg < hi_len;
      phase_reg <= (phase_reg == hi_len + lo_len - 16'h0001) ? 16'h0000 : phase_reg + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// File: testbench/wtm_top_props.sv
// checker on the wide timer apb and interrupt ports
// assumes a bind from the bench top onto wtm_top
`timescale 1ns/1ps
`default_nettype none
module wtm_top_props
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        event_input_pin,
  input wire logic        wide_timer_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // setup decode; unaligned addresses up to 12'h010 left out, their answer is open
  wire setup = psel && !penable;
  wire miss  = paddr > 12'h010;
  wire hit   = !miss && paddr[1:0] == 2'b00;
  wire mclr  = pready && pwrite && paddr == 12'h010 && pwdata[1:0] == 2'b00;
  AST_SETUP_READY: assert property (setup |=> pready)
    else $error("no ready after setup");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_IDLE_NO_READY: assert property (!psel |=> !pready)
    else $error("ready without request");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error outside access");
  AST_MISS_ERR: assert property (setup && miss |=> pslverr)
    else $error("unmapped address accepted");
  AST_HIT_OK: assert property (setup && hit |=> !pslverr)
    else $error("mapped address refused");
  AST_BYTE_READ: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read wider than a byte");
  AST_MASK_OFF_IRQ: assert property (mclr |=> ##1 !wide_timer_irq)
    else $error("irq stays up with mask clear");
endmodule
`default_nettype wire
